// ===== sys_csr_device.sv
// Overview of operation
// - Timer count readable, 16 bits, resets FFFFh
// - Default: A1 set selects upper half
// - Swap all ones: A1 set selects lower
// - 32-bit 25 MHz counter, zero at reset
// - First half read latches whole counter
// - Counter clears within 160 ns of reset
// - Counter runs in every power state
// - Dropped frames counted, zero after reset
// - Reading drop counter returns then clears
// - Event when drop counter reaches midpoint
// - Busy bit starts access, self clears
// - Read data loaded in the same cycle busy clears
// - Host leaves command/data alone while busy
// - Bit 30 picks read or write
// - Bits 7-0 pick MAC register index
// - Data register carries indirect value, resets zero
// - Timer enable bit; falling edge presets preload
//
// The APB interface to the registers was left to the implementer.
module sys_csr_device
    import sys_csr_pkg::*;
#(
    parameter int TICK_CYCLES = GPT_TICK_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host bus
    sram_link_if.dev link,
    // Receive path
    input wire logic frame_dropped,
    output logic drop_half_event,
    // MAC register port
    output logic mac_req,
    output logic mac_write,
    output logic [MAC_IDX_W-1:0] mac_index,
    output logic [31:0] mac_wdata,
    input wire logic [31:0] mac_rdata,
    input wire logic mac_ack
);

    // Whole state of the device end
    typedef struct packed {
        logic [31:0] word_swap;     // Half-word mapping control
        logic timer_en;             // Timer run bit
        logic [15:0] preload;       // Timer preload
        logic [15:0] timer_cnt;     // Present timer count
        logic [15:0] tick_div;      // Timer tick divider
        logic fr_phase;             // 50 to 25 MHz divider
        logic [31:0] tick_count_field;        // Free-running count
        logic [31:0] fr_snap;       // Sample for the second half read
        logic fr_pend;              // Second half still owed
        logic [31:0] drop_cnt;      // Dropped frame tally
        logic [31:0] drop_snap;     // Sample for the second half read
        logic drop_pend;            // Second half still owed
        logic drop_evt;             // Midpoint event
        logic cmd_dir;              // Indirect direction, 1 = read
        logic [MAC_IDX_W-1:0] cmd_idx;  // Indirect target
        logic [31:0] mac_data;      // Indirect data word
        mac_st_e mac_st;            // Indirect access state
        logic [15:0] rdata;         // Read data to host
    } dev_state_s;

    dev_state_s q;
    dev_state_s d;

    // Decoded host access
    logic wr_hit;
    logic rd_hit;
    logic hi;
    logic [7:0] off;
    logic [31:0] fr_inc;

    assign wr_hit = !link.cs_n && !link.wr_n;
    assign rd_hit = !link.cs_n && !link.rd_n;
    assign off = {link.addr[7:2], 2'b00};
    // Swap only reverses which half A1 reaches; never the stored layout
    assign hi = link.addr[1] ^ (q.word_swap == SWAP_ALL_ONES);

    // Next state
    always_comb
    begin
        d = q;
        d.drop_evt = 1'b0;

        // Free-running counter at half the system rate, in every power state
        d.fr_phase = !q.fr_phase;
        fr_inc = q.tick_count_field + 32'h00000001;
        if (q.fr_phase)
        begin
            d.tick_count_field = fr_inc;
        end

        // Timer tick divider and countdown
        if (q.timer_en)
        begin
            if (q.tick_div == 16'(TICK_CYCLES - 1))
            begin
                d.tick_div = HALF_ZERO;
                d.timer_cnt = (q.timer_cnt == HALF_ZERO) ? q.preload : q.timer_cnt - 16'h0001;
            end
            else
            begin
                d.tick_div = q.tick_div + 16'h0001;
            end
        end

        // Drop tally; midpoint crossing flagged once
        if (frame_dropped)
        begin
            d.drop_cnt = q.drop_cnt + 32'h00000001;
            d.drop_evt = (q.drop_cnt == DROP_BELOW_HALF);
        end

        // Host writes, 16 bits at a time
        if (wr_hit)
        begin
            case (off)
                OFF_TIMER_CFG:
                begin
                    if (hi)
                    begin
                        d.timer_en = link.wdata[TIMER_EN_HBIT];
                        // Start from the preload when switched on
                        if (link.wdata[TIMER_EN_HBIT] && !q.timer_en)
                        begin
                            d.timer_cnt = q.preload;
                            d.tick_div = HALF_ZERO;
                        end
                        if (!link.wdata[TIMER_EN_HBIT] && q.timer_en)
                        begin
                            d.preload = TIMER_RESET;
                        end
                    end
                    else
                    begin
                        d.preload = link.wdata;
                    end
                end
                OFF_WORD_SWAP:
                begin
                    d.word_swap = put_half(q.word_swap, link.wdata, hi);
                end
                OFF_MAC_CMD:
                begin
                    // Writes during a busy access are dropped
                    if (q.mac_st == MAC_IDLE)
                    begin
                        if (hi)
                        begin
                            d.cmd_dir = link.wdata[CMD_DIR_HBIT];
                            if (link.wdata[CMD_BUSY_HBIT])
                            begin
                                d.mac_st = MAC_BUSY;
                            end
                        end
                        else
                        begin
                            d.cmd_idx = link.wdata[MAC_IDX_W-1:0];
                        end
                    end
                end
                OFF_MAC_DATA:
                begin
                    if (q.mac_st == MAC_IDLE)
                    begin
                        d.mac_data = put_half(q.mac_data, link.wdata, hi);
                    end
                end
                default:
                begin
                    d.mac_st = d.mac_st; // Read-only or unmapped: ignored
                end
            endcase
        end

        // Host reads; the two counters sample on the first half
        if (rd_hit)
        begin
            case (off)
                OFF_TIMER_CNT:
                    d.rdata = get_half({HALF_ZERO, q.timer_cnt}, hi);
                OFF_TIMER_CFG:
                    d.rdata = get_half({2'b00, q.timer_en, 13'h0000, q.preload}, hi);
                OFF_WORD_SWAP:
                    d.rdata = get_half(q.word_swap, hi);
                OFF_FREE_RUN:
                begin
                    d.rdata = get_half(q.fr_pend ? q.fr_snap : q.tick_count_field, hi);
                    d.fr_snap = q.tick_count_field;
                    d.fr_pend = !q.fr_pend;
                end
                OFF_DROP_CNT:
                begin
                    d.rdata = get_half(q.drop_pend ? q.drop_snap : q.drop_cnt, hi);
                    if (!q.drop_pend)
                    begin
                        // A drop in the same cycle lands after the clear
                        d.drop_snap = q.drop_cnt;
                        d.drop_cnt = frame_dropped ? 32'h00000001 : WORD_ZERO;
                    end
                    d.drop_pend = !q.drop_pend;
                end
                OFF_MAC_CMD:
                    d.rdata = get_half({q.mac_st == MAC_BUSY, q.cmd_dir, 22'h000000,
                                        q.cmd_idx}, hi);
                OFF_MAC_DATA:
                    d.rdata = get_half(q.mac_data, hi);
                default:
                    d.rdata = HALF_ZERO;
            endcase
        end

        // Indirect access completes on the MAC acknowledge
        if ((q.mac_st == MAC_BUSY) && mac_ack)
        begin
            if (q.cmd_dir)
            begin
                d.mac_data = mac_rdata;
            end
            d.mac_st = MAC_IDLE;
        end
    end

    // State register; synchronous reset clears the counter on the first clock edge with rstn low
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.timer_cnt <= TIMER_RESET;
            q.preload <= TIMER_RESET;
            q.mac_st <= MAC_IDLE;
            q.tick_count_field <= WORD_ZERO;
        end
        else
        begin
            q <= d;
        end
    end

    // MAC port held steady for the whole access
    assign mac_req = (q.mac_st == MAC_BUSY);
    assign mac_write = !q.cmd_dir;
    assign mac_index = q.cmd_idx;
    assign mac_wdata = q.mac_data;
    assign drop_half_event = q.drop_evt;
    assign link.rdata = q.rdata;

endmodule

// ===== sys_csr_pkg.sv
package sys_csr_pkg;

    // Device register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFF_TIMER_CFG = 8'h8C;
    localparam logic [7:0] OFF_TIMER_CNT = 8'h90;
    localparam logic [7:0] OFF_WORD_SWAP = 8'h98;
    localparam logic [7:0] OFF_FREE_RUN = 8'h9C;
    localparam logic [7:0] OFF_DROP_CNT = 8'hA0;
    localparam logic [7:0] OFF_MAC_CMD = 8'hA4;
    localparam logic [7:0] OFF_MAC_DATA = 8'hA8;

    // Field positions within the upper half-word of a register; index width in the lower half
    localparam int TIMER_EN_HBIT = 13;
    localparam int CMD_BUSY_HBIT = 15;
    localparam int CMD_DIR_HBIT = 14;
    localparam int MAC_IDX_W = 8;

    // Reset and compare values
    localparam logic [15:0] TIMER_RESET = 16'hFFFF;
    localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] DROP_BELOW_HALF = 32'h7FFFFFFF;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;

    // Timing: 50 MHz system clock, 25 MHz free-run rate, 100 us timer tick
    localparam int CLK_PERIOD_NS = 20;
    localparam int GPT_TICK_NS = 100000;
    localparam int GPT_TICK_CYCLES = GPT_TICK_NS / CLK_PERIOD_NS;

    // Host controller registers on APB
    localparam logic [7:0] HREG_CMD = 8'h00;
    localparam logic [7:0] HREG_WDATA = 8'h04;
    localparam logic [7:0] HREG_STATUS = 8'h08;
    localparam logic [7:0] HREG_RDATA = 8'h0C;
    localparam int HCMD_DIR_BIT = 8;
    localparam int HST_BUSY_BIT = 0;
    localparam int HST_MACBUSY_BIT = 1;
    localparam int HST_REFUSED_BIT = 2;

    // Indirect MAC access states
    typedef enum logic [1:0] {
        MAC_IDLE = 2'b01,
        MAC_BUSY = 2'b10
    } mac_st_e;

    // Host link transfer states
    typedef enum logic [2:0] {
        LNK_IDLE = 3'b001,
        LNK_STROBE = 3'b010,
        LNK_CAPTURE = 3'b100
    } lnk_st_e;

    // Select one half-word of a register
    function automatic logic [15:0] get_half(input logic [31:0] w, input logic hi);
        return hi ? w[31:16] : w[15:0];
    endfunction

    // Replace one half-word of a register
    function automatic logic [31:0] put_half(input logic [31:0] w, input logic [15:0] h,
                                             input logic hi);
        return hi ? {h, w[15:0]} : {w[31:16], h};
    endfunction

    // True for the two words of the indirect access pair
    function automatic logic is_mac_pair(input logic [7:0] off);
        return (off == OFF_MAC_CMD) || (off == OFF_MAC_DATA);
    endfunction

endpackage

// ===== sram_link_if.sv
interface sram_link_if (input wire logic sys_clk);
    import sys_csr_pkg::*;

    // Host to device strobes and address, active low
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:1] addr;
    logic [15:0] wdata;
    // Device to host read data
    logic [15:0] rdata;

    modport dev (input cs_n, input rd_n, input wr_n, input addr, input wdata, output rdata);
    modport hst (output cs_n, output rd_n, output wr_n, output addr, output wdata, input rdata);
endinterface

// ===== sys_csr_host.sv
module sys_csr_host
    import sys_csr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device bus
    sram_link_if.hst link
);

    // Whole state of the host end
    typedef struct packed {
        lnk_st_e st;            // Link transfer state
        logic ack;              // APB answer cycle
        logic [31:0] prdata;    // APB read data
        logic [7:1] addr;       // Device half-word address
        logic dir;              // 1 = read
        logic [15:0] wdata;     // Write half-word
        logic [15:0] rdata;     // Last read half-word
        logic mac_busy;         // Device indirect access believed busy
        logic refused;          // Sticky: write held back
    } host_state_s;

    host_state_s q;
    host_state_s d;

    logic apb_acc;
    logic known;
    logic [7:0] dev_off;

    assign apb_acc = psel && penable;
    assign known = (paddr == HREG_CMD) || (paddr == HREG_WDATA) ||
                   (paddr == HREG_STATUS) || (paddr == HREG_RDATA);
    assign dev_off = {pwdata[7:2], 2'b00};

    // Next state
    always_comb
    begin
        d = q;
        // One wait state so that read data comes from a flop
        d.ack = apb_acc && !q.ack;
        if (apb_acc && !q.ack)
        begin
            case (paddr)
                HREG_STATUS:
                    d.prdata = {29'h00000000, q.refused, q.mac_busy, q.st != LNK_IDLE};
                HREG_RDATA:
                    d.prdata = {HALF_ZERO, q.rdata};
                HREG_WDATA:
                    d.prdata = {HALF_ZERO, q.wdata};
                default:
                    d.prdata = WORD_ZERO;
            endcase
        end

        // Link sequence: strobe one cycle, then capture
        case (q.st)
            LNK_STROBE:
                d.st = LNK_CAPTURE;
            LNK_CAPTURE:
            begin
                d.st = LNK_IDLE;
                if (q.dir)
                begin
                    d.rdata = link.rdata;
                    // Busy clear seen on the command word ends the guard
                    if ({q.addr[7:2], 2'b00} == OFF_MAC_CMD && !link.rdata[CMD_BUSY_HBIT])
                    begin
                        d.mac_busy = 1'b0;
                    end
                end
            end
            default:
                d.st = LNK_IDLE;
        endcase

        // APB writes take effect at the answer edge
        if (apb_acc && q.ack && pwrite)
        begin
            case (paddr)
                HREG_WDATA:
                    d.wdata = pwdata[15:0];
                HREG_STATUS:
                    d.refused = q.refused && !pwdata[HST_REFUSED_BIT];
                HREG_CMD:
                begin
                    if (q.st == LNK_IDLE)
                    begin
                        // No writes to the command/data pair while busy
                        if (!pwdata[HCMD_DIR_BIT] && q.mac_busy && is_mac_pair(dev_off))
                        begin
                            d.refused = 1'b1;
                        end
                        else
                        begin
                            d.addr = pwdata[7:1];
                            d.dir = pwdata[HCMD_DIR_BIT];
                            d.st = LNK_STROBE;
                            if (!pwdata[HCMD_DIR_BIT] && dev_off == OFF_MAC_CMD &&
                                q.wdata[CMD_BUSY_HBIT])
                            begin
                                d.mac_busy = 1'b1;
                            end
                        end
                    end
                end
                default:
                    d.refused = d.refused;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.st <= LNK_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs
    assign pready = q.ack;
    assign pslverr = q.ack && !known;
    assign prdata = q.prdata;
    assign link.cs_n = (q.st != LNK_STROBE);
    assign link.rd_n = !((q.st == LNK_STROBE) && q.dir);
    assign link.wr_n = !((q.st == LNK_STROBE) && !q.dir);
    assign link.addr = q.addr;
    assign link.wdata = q.wdata;

endmodule

// ===== sys_csr_link_chk.sv
module sys_csr_link_chk
    import sys_csr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host link wires
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:1] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    // Device side ports
    input wire logic mac_req,
    input wire logic mac_write,
    input wire logic [7:0] mac_index,
    input wire logic [31:0] mac_wdata,
    input wire logic mac_ack,
    input wire logic drop_half_event
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Link write into the command or data word
    logic pair_wr;
    assign pair_wr = !cs_n && !wr_n && (addr[7:2] == 6'h29 || addr[7:2] == 6'h2A);

    chk_busy_holds: assert property (mac_req && !mac_ack |=> mac_req)
        else $error("busy dropped before ack");
    chk_busy_clears: assert property (mac_req && mac_ack |=> !mac_req)
        else $error("busy stuck after ack");
    chk_start_cause: assert property ($rose(mac_req) |->
        $past(!cs_n && !wr_n && addr[7:2] == 6'h29 && wdata[15]))
        else $error("access started without start bit");
    chk_index_held: assert property (mac_req && !mac_ack |=> $stable(mac_index))
        else $error("index moved while busy");
    chk_dir_held: assert property (mac_req && !mac_ack |=> $stable(mac_write))
        else $error("direction moved while busy");
    chk_wdata_held: assert property (mac_req && !mac_ack |=> $stable(mac_wdata))
        else $error("write data moved while busy");
    chk_no_busy_write: assert property (mac_req |-> !pair_wr)
        else $error("command or data written while busy");
    chk_strobe_single: assert property (!cs_n |=> cs_n)
        else $error("select held longer than one cycle");
    chk_rdata_stands: assert property (rd_n |=> $stable(rdata))
        else $error("read data moved without a read");
    // Tally cannot reach its midpoint in a short run
    chk_no_half_event: assert property (!drop_half_event)
        else $error("midpoint event too early");

    // Main scenarios reached
    cov_write_start: cover property ($rose(mac_req) && mac_write);
    cov_read_start: cover property ($rose(mac_req) && !mac_write);
    cov_link_read: cover property (!cs_n && !rd_n);
endmodule

// ===== tb_system_counters_csr_bridge.sv
module tb_system_counters_csr_bridge
    import sys_csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Clock, reset and APB
    logic sys_clk, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    // Receive path and MAC port
    logic frame_dropped = 0, drop_half_event, mac_req, mac_write, mac_ack = 0;
    logic [7:0] mac_index;
    logic [31:0] mac_wdata, mac_rdata = 0;
    // Bench state
    integer errors = 0, n_checks = 0, seed = 32'hCDA0, dly = 0, wcnt = 0, k, i, n;
    logic want = 0, mreq_q = 0;
    logic [31:0] v, d, rv;
    logic [7:0] x;
    logic [40:0] exp_q[$], msk_q[$], mac_q[$];
    logic [7:0] ra[9] = '{8'h90, 8'h92, 8'h98, 8'h9A, 8'hA0, 8'hA2, 8'hA4, 8'hA6, 8'hA8};
    logic [15:0] re[9] = '{16'hFFFF, 0, 0, 0, 0, 0, 0, 0, 0};

    // Free-running bench clock
    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end

    sram_link_if i_sram_link_if (.sys_clk(sys_clk));
    // Short tick keeps the timer lively in simulation
    sys_csr_device #(.TICK_CYCLES(4)) i_sys_csr_device (.sys_clk(sys_clk), .rstn(rstn),
        .link(i_sram_link_if), .frame_dropped(frame_dropped),
        .drop_half_event(drop_half_event), .mac_req(mac_req), .mac_write(mac_write),
        .mac_index(mac_index), .mac_wdata(mac_wdata), .mac_rdata(mac_rdata),
        .mac_ack(mac_ack));
    sys_csr_host i_sys_csr_host (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(i_sram_link_if));
    sys_csr_link_chk i_sys_csr_link_chk (.sys_clk(sys_clk), .rstn(rstn),
        .cs_n(i_sram_link_if.cs_n), .rd_n(i_sram_link_if.rd_n), .wr_n(i_sram_link_if.wr_n),
        .addr(i_sram_link_if.addr), .wdata(i_sram_link_if.wdata),
        .rdata(i_sram_link_if.rdata), .mac_req(mac_req), .mac_write(mac_write),
        .mac_index(mac_index), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
        .drop_half_event(drop_half_event));

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Masked compare, used for both kinds of result
    task automatic cmp(input logic [40:0] got, input logic [40:0] e, input logic [40:0] m);
        n_checks++;
        if ((got & m) !== (e & m))
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, e);
        end
    endtask

    // A wait that ran out
    task automatic hang();
        errors++;
        $display("[ERR] %0t wait ran out", $time);
        end_of_test();
    endtask

    // One APB transfer; c marks a read whose result is checked
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic c, output logic [31:0] r);
        integer t;
        t = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        want <= c;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Hold the request until ready is seen
        do
        begin
            @(posedge sys_clk);
            t++;
        end
        while (pready !== 1'b1 && t < 40);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        want <= 1'b0;
        if (t >= 40)
            hang();
    endtask

    // Wait until the host link is idle again
    task automatic idle();
        integer t;
        logic [31:0] s;
        t = 0;
        do
        begin
            apb(1'b0, HREG_STATUS, 0, 1'b0, s);
            t++;
        end
        while (s[HST_BUSY_BIT] !== 1'b0 && t < 20);
        if (t >= 20)
            hang();
    endtask

    // Device half-word write through the host
    task automatic lwr(input logic [7:0] a, input logic [15:0] wd);
        logic [31:0] r;
        apb(1'b1, HREG_WDATA, {16'h0, wd}, 1'b0, r);
        apb(1'b1, HREG_CMD, {24'h0, a}, 1'b0, r);
        idle();
    endtask

    // Device half-word read through the host
    task automatic lrd(input logic [7:0] a, input logic c, output logic [31:0] r);
        apb(1'b1, HREG_CMD, {23'h0, 1'b1, a}, 1'b0, r);
        idle();
        apb(1'b0, HREG_RDATA, 0, c, r);
    endtask

    // Read and check one device half-word
    task automatic lchk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] r;
        exp_q.push_back({25'h0, e});
        msk_q.push_back(41'hFFFF);
        lrd(a, 1'b1, r);
    endtask

    // Result watcher: APB reads and MAC requests
    always @(posedge sys_clk)
    begin
        if (psel && penable && pready && want)
            cmp({8'h0, pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
        if (mac_req && !mreq_q)
            cmp({mac_write, mac_index, mac_wdata}, mac_q.pop_front(), '1);
        mreq_q <= mac_req;
    end

    // MAC side: acks after dly+1 cycles of busy
    always @(posedge sys_clk)
    begin
        mac_ack <= 1'b0;
        if (!mac_req || mac_ack)
            wcnt <= dly;
        else if (wcnt == 0)
            mac_ack <= 1'b1;
        else
            wcnt <= wcnt - 1;
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset values, both halves so latched words re-arm
        for (i = 0; i < 9; i++)
            lchk(ra[i], re[i]);
        $display("reset values done");
        // Drop tally: random drop pattern, paired half, clear on read
        k = 0;
        repeat (24)
        begin
            @(posedge sys_clk);
            n = $random(seed);
            frame_dropped <= n[0];
            // Each driven level is sampled exactly once by the device
            k = k + n[0];
        end
        @(posedge sys_clk);
        frame_dropped <= 1'b0;
        lchk(OFF_DROP_CNT, k[15:0]);
        lchk(OFF_DROP_CNT + 8'h2, 16'h0);
        lchk(OFF_DROP_CNT, 16'h0);
        // Free-run: same half read twice returns one sample
        lrd(OFF_FREE_RUN, 1'b0, v);
        lchk(OFF_FREE_RUN, v[15:0]);
        lchk(OFF_FREE_RUN + 8'h2, 16'h0);
        $display("counters done");
        // Indirect write (slow MAC), then read (prompt MAC)
        for (i = 0; i < 2; i++)
        begin
            d = $random(seed);
            x = $random(seed);
            rv = $random(seed);
            lwr(OFF_MAC_DATA, d[15:0]);
            lwr(OFF_MAC_DATA + 8'h2, d[31:16]);
            lwr(OFF_MAC_CMD, {8'h0, x});
            mac_rdata <= rv;
            dly <= (i == 0) ? 40 : 0;
            mac_q.push_back({i == 0, x, d});
            lwr(OFF_MAC_CMD + 8'h2, (i == 0) ? 16'h8000 : 16'hC000);
            if (i == 0)
            begin
                // Write while busy must be refused
                lwr(OFF_MAC_DATA, 16'hDEAD);
                exp_q.push_back(41'h4);
                msk_q.push_back(41'h4);
                apb(1'b0, HREG_STATUS, 0, 1'b1, v);
                apb(1'b1, HREG_STATUS, 32'h4, 1'b0, v);
            end
            n = 0;
            do
            begin
                lrd(OFF_MAC_CMD + 8'h2, 1'b0, v);
                n++;
            end
            while (v[15] !== 1'b0 && n < 50);
            if (n >= 50)
                hang();
            if (i == 1)
                d = rv;
            lchk(OFF_MAC_DATA, d[15:0]);
            lchk(OFF_MAC_DATA + 8'h2, d[31:16]);
            lchk(OFF_MAC_CMD + 8'h2, (i == 0) ? 16'h0 : 16'h4000);
            lchk(OFF_MAC_CMD, {8'h0, x});
        end
        $display("indirect access done");
        // Word swap: only all ones reverses halves
        lwr(OFF_MAC_DATA, 16'h1234);
        lwr(OFF_MAC_DATA + 8'h2, 16'h5678);
        lwr(OFF_WORD_SWAP, 16'hFFFF);
        lwr(OFF_WORD_SWAP + 8'h2, 16'hFFFF);
        lchk(OFF_MAC_DATA, 16'h5678);
        lchk(OFF_MAC_DATA + 8'h2, 16'h1234);
        lwr(OFF_WORD_SWAP, 16'h0);
        lchk(OFF_WORD_SWAP, 16'hFFFF);
        lchk(OFF_MAC_DATA, 16'h1234);
        lwr(OFF_WORD_SWAP, 16'h0);
        $display("word swap done");
        // Timer disable presets the preload
        lwr(OFF_TIMER_CFG, 16'h1234);
        lchk(OFF_TIMER_CFG, 16'h1234);
        lwr(OFF_TIMER_CFG + 8'h2, 16'h2000);
        lwr(OFF_TIMER_CFG + 8'h2, 16'h0);
        lchk(OFF_TIMER_CFG, 16'hFFFF);
        // Unmapped places
        lchk(8'h50, 16'h0);
        exp_q.push_back(41'h1_0000_0000);
        msk_q.push_back(41'h1_0000_0000);
        apb(1'b0, 8'h10, 0, 1'b1, v);
        $display("timer and unmapped done");
        end_of_test();
    end
endmodule
